// ---- dv/polled_pin_event_unit_bench.sv ----
// self-checking bench of the polled pin-event unit with an integer model
`timescale 1ns/1ns
`default_nettype none
module polled_pin_event_unit_bench;
   logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic instr_boundary = 1'h0, wait_req = 1'h0, pready, pslverr, wait_release, slot_switch, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [2:0] slot_target;
   logic [15:0] sw = 16'hffff, pin_in, pin_out, pin_oe, keep;
   int mismatches = 0, tests_run = 0, cyc = 0, im = 0, il = 0, om = 0, oa = 0, md = 0, lat = 0, st = 0, sl;
   ppe_core ppe_core_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_boundary(instr_boundary), .wait_req(wait_req), .wait_release(wait_release),
      .slot_switch(slot_switch), .slot_target(slot_target), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   ppe_pins_model ppe_pins_model_inst (.sw(sw), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one apb transfer; read data and error are taken at the edge that sees pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   // mode write; clear codes keep the mode and only drop configuration
   task automatic setm(input int m);
      apb(1'h1, ppe_pkg::OFS_MODE, m);
      if (m % 8 == 0 || m % 8 == 5 || m % 8 == 7) im = 0;
      if (m % 8 == 0 || m % 8 >= 6) om = 0;
      if (m % 8 < 5) md = m;
   endtask
   task automatic dfn(input logic o, input int p, input int l);
      apb(1'h1, o ? ppe_pkg::OFS_OUT_DEF : ppe_pkg::OFS_IN_DEF, l << ppe_pkg::DEF_LEVEL_BIT | p);
      if (o) begin
         om |= 1 << p;
         oa = oa & ~(1 << p) | l << p;
      end else begin
         im |= 1 << p;
         il = il & ~(1 << p) | l << p;
      end
   endtask
   // set switches, let the two-flop synchroniser settle, then one instruction boundary
   task automatic poll(input int v);
      int t;
      sw <= v[15:0];
      repeat (3) @(posedge clk);
      t = (~(v ^ il) & im) != 0;
      instr_boundary <= 1'h1;
      @(posedge clk);
      instr_boundary <= 1'h0;
      @(posedge clk);
      if (md % 8 == 2 || md % 8 == 4) begin
         lat = lat | (t & md >= 8);
         st = lat | t;
      end
      if (t && (md % 8 == 3 || md % 8 == 4)) md = md - 2;
      chk(pin_out & om, (st ? oa : ~oa) & om);
      chk(pin_oe & (om | im), om);
   endtask
   initial begin
      void'($urandom(32'hfdd09ac0));
      repeat (6) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      chk(pin_oe, 16'h0000);
      chk(pready, 1'h1);
      apb(1'h0, ppe_pkg::OFS_MODE, 0);
      chk(r, 32'h0);
      // two inputs watched for low, two high-active outputs and one random output
      dfn(1'h0, 0, 0);
      dfn(1'h0, 1, 0);
      dfn(1'h1, 2, 1);
      dfn(1'h1, 3, 1);
      dfn(1'h1, 4 + $urandom % 12, $urandom % 2);
      setm(2);
      for (int v = 0; v < 4; v++) poll($urandom & 32'hfffc | v);
      setm(1);
      poll(0);
      setm(2);
      poll(0);
      wait_req <= 1'h1;
      @(posedge clk);
      wait_req <= 1'h0;
      @(posedge clk);
      chk(wait_release, 1'h1);
      setm(3);
      wait_req <= 1'h1;
      repeat (3) @(posedge clk);
      wait_req <= 1'h0;
      chk(wait_release, 1'h0);
      sl = $urandom % 8;
      apb(1'h1, ppe_pkg::OFS_SLOT, sl);
      poll(0);
      @(posedge clk);
      chk(slot_switch, 1'h1);
      chk(slot_target, sl);
      apb(1'h0, ppe_pkg::OFS_MODE, 0);
      chk(r, md);
      setm(4);
      poll(3);
      poll(0);
      @(posedge clk);
      chk(slot_switch, 1'h1);
      apb(1'h0, ppe_pkg::OFS_MODE, 0);
      chk(r, md);
      // latched outputs hold until software clears the latch
      apb(1'h1, ppe_pkg::OFS_CLEAR, 1);
      setm(10);
      poll(0);
      poll(3);
      apb(1'h1, ppe_pkg::OFS_CLEAR, 1);
      lat = 0;
      poll(3);
      keep = pin_out;
      setm(14);
      poll(0);
      chk(pin_out, keep);
      apb(1'h0, ppe_pkg::OFS_MODE, 0);
      chk(r, md);
      apb(1'h0, {ppe_pkg::SCR_FIRST + 10'h002, 2'h0}, 0);
      chk(r, md);
      apb(1'h0, 12'hffc, 0);
      chk(err, 1'h1);
      for (int m = 0; m < 16; m++) begin
         setm(m);
         apb(1'h0, ppe_pkg::OFS_MODE, 0);
         chk(r, md);
      end
      close_out();
   end
endmodule
`default_nettype wire

// ---- dv/ppe_core_chk.sv ----
// port assertions of the polled pin-event unit
`timescale 1ns/1ns
`default_nettype none
module ppe_core_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic instr_boundary,
   input wire logic wait_req,
   input wire logic wait_release,
   input wire logic slot_switch,
   input wire logic [2:0] slot_target,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic wr;
   // a register write is the only software cause of a pin or slot change
   assign wr = psel & penable & pwrite;
   // one evaluation followed by a quiet cycle
   sequence s_eval_quiet;
      instr_boundary ##1 !instr_boundary && !wait_req && !wr;
   endsequence
   // a slot switch followed by idle bus cycles, so nothing can re-arm it
   sequence s_switch_idle;
      slot_switch && !wr && !$past(wr) ##1 !wr [*4];
   endsequence
   AST_OUT_BEFORE_SWITCH: assert property (s_eval_quiet ##1 slot_switch |-> $stable(pin_out) && $stable(pin_oe))
      else $error("outputs moved in the slot switch cycle");
   AST_SWITCH_CAUSE: assert property (slot_switch |-> $past(instr_boundary, 2) || $past(wait_req, 2))
      else $error("slot switch without an evaluation");
   AST_SWITCH_ONCE: assert property (slot_switch |=> !slot_switch)
      else $error("slot switch longer than one cycle");
   AST_NO_REARM: assert property (s_switch_idle |-> !slot_switch)
      else $error("slot switch repeated without a new mode");
   AST_WAIT_CAUSE: assert property (wait_release |-> $past(wait_req))
      else $error("wait released without a request");
   AST_RESET_RELEASE: assert property (disable iff (1'h0) sys_rst |=> !pin_oe && !slot_switch && !wait_release)
      else $error("pins driven or pulses seen in reset");
   AST_OUT_CAUSE: assert property (!instr_boundary && !wait_req && !wr |=> $stable(pin_out) && $stable(pin_oe))
      else $error("pin changed without evaluation or write");
   AST_SLOT_HOLD: assert property (!wr |=> $stable(slot_target))
      else $error("slot target changed without a write");
endmodule
bind ppe_core ppe_core_chk ppe_core_chk_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .instr_boundary(instr_boundary), .wait_req(wait_req), .wait_release(wait_release),
   .slot_switch(slot_switch), .slot_target(slot_target), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ---- dv/ppe_pins_model.sv ----
// far-side model: switches on the pins, with driven pins reading back their own level
`timescale 1ns/1ns
`default_nettype none
module ppe_pins_model (
   input wire logic [15:0] sw,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   output logic [15:0] pin_in
);
   // an undriven pin shows its switch; a driven one echoes the unit, as a real pad would
   assign pin_in = (pin_out & pin_oe) | (sw & ~pin_oe);
endmodule
`default_nettype wire

// ---- rtl/ppe_core.sv ----
// top of the polled pin-event unit: apb registers, mode handling, output drive
// Operation
// R1 - configuration stays in force until rewritten or cleared
// R2 - while active, inputs evaluated and outputs updated at every instruction boundary
// R3 - any number of pins may be watched inputs and reacting outputs
// R4 - trigger is the OR of all watched-input matches
// R5 - non-latched outputs follow the trigger continuously
// R6 - latched outputs go active on first trigger and hold until software clears
// R7 - trigger may drive outputs, switch program slot, release a wait, or combine
// R8 - mode takes values 0 to 15 and governs processing
// R9 - wait for trigger served only in modes 2 and 4
// R10 - outputs update before the slot switch of the same trigger
// R11 - polling status readable in scratch locations 128 to 135
// R12 - outputs change continuously, once, or not at all, by mode
// R13 - mode codes: 0 off clear, 1 off keep, 2 out, 3 run, 4 both, 5-7 clear
// R14 - modes 8 to 15 act as 0 to 7 with latched outputs
// R15 - after a slot switch mode 3 becomes 1 and mode 4 becomes 2
// R16 - inputs sampled after an instruction ends, before the next fetch
// R17 - watched input has pin index and level; defining it forces input direction
// R18 - reset clears configuration, disables polling, releases outputs
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ppe_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_boundary,
   input wire logic wait_req,
   output logic wait_release,
   output logic slot_switch,
   output logic [2:0] slot_target,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe
);
   // timing seen from outside:
   // - an apb access phase always lasts one cycle, read data is captured in the setup cycle
   // - an evaluation edge moves the pins one cycle later
   // - the slot switch pulse follows one cycle after that, so pins always lead the switch
   // - a wait release is a one-cycle pulse one cycle after the evaluation edge
   // the sequencer owns the timing of boundaries; this block never stalls it
   // limitation: a boundary strobe that arrives while a slot switch is pending
   // cannot re-arm the switch, so a second trigger in that gap is dropped on purpose
   //
   // all state lives in one packed struct, registered in one process
   typedef struct packed {
      // polling configuration
      logic [3:0] mode;
      logic [15:0] in_mask;
      logic [15:0] in_level;
      logic [15:0] out_mask;
      logic [15:0] out_level;
      // trigger response state
      logic out_state;
      logic [15:0] hit;
      logic [2:0] slot;
      logic slot_pend;
      logic slot_pulse;
      logic wait_pulse;
      // plain pins not under polling control
      logic [15:0] gp_out;
      logic [15:0] gp_dir;
      // registered pin drive and bus answer
      logic [15:0] pin_out;
      logic [15:0] pin_oe;
      logic [31:0] prdata;
      logic pslverr;
   } ppe_state_t;

   ppe_state_t r_reg;
   ppe_state_t r_next;
   ppe_sample_if smp ();

   ppe_sampler u_sampler (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in(pin_in),
      .smp(smp)
   );

   assign smp.watch_mask = r_reg.in_mask;
   assign smp.watch_level = r_reg.in_level;

   // mode decode
   logic [2:0] base;
   logic latched;
   logic active;
   logic outs_on;
   logic run_on;
   logic eval;
   logic trig;
   logic [15:0] hit_set;
   logic wr;
   logic setup;
   logic [3:0] def_idx;
   logic [9:0] word_idx;
   // outputs that leave polling keep their level as plain gpio outputs
   logic [15:0] keep_out;
   logic [15:0] keep_dir;

   always_comb begin
      base = r_reg.mode[2:0];
      latched = r_reg.mode[ppe_pkg::MODE_LATCH_BIT]; // see R14
      active = (base == ppe_pkg::M_OUT_WAIT) || (base == ppe_pkg::M_RUN) || (base == ppe_pkg::M_OUT_RUN);
      outs_on = (base == ppe_pkg::M_OUT_WAIT) || (base == ppe_pkg::M_OUT_RUN); // see R13
      run_on = (base == ppe_pkg::M_RUN) || (base == ppe_pkg::M_OUT_RUN);
      // boundary strobe marks the gap between one instruction and the next fetch
      eval = active && (instr_boundary || (wait_req && outs_on)); // see R2, R16, R9
      trig = smp.trigger;
      hit_set = eval ? smp.match : 16'h0000;
      wr = psel && penable && pwrite;
      setup = psel && !penable;
      def_idx = pwdata[ppe_pkg::DEF_IDX_LSB +: 4];
      word_idx = paddr[11:2];
      // a cleared output must not glitch, so its present level moves into the gpio register
      keep_out = (r_reg.gp_out & ~r_reg.out_mask) | (r_reg.pin_out & r_reg.out_mask);
      keep_dir = r_reg.gp_dir | r_reg.out_mask;
   end

   // next-state: polling evaluation first, software writes afterwards so they win on config
   always_comb begin
      r_next = r_reg;
      r_next.slot_pulse = 1'b0;
      r_next.wait_pulse = 1'b0;
      r_next.hit = r_reg.hit | hit_set; // see R11

      // outputs react to the trigger in modes 2 and 4 only
      if (eval && outs_on) begin
         if (latched) begin
            r_next.out_state = r_reg.out_state | trig; // see R6
         end else begin
            r_next.out_state = trig; // see R5, R12
         end
      end

      // slot switch fires a cycle after the outputs have moved
      if (r_reg.slot_pend) begin
         r_next.slot_pulse = 1'b1; // see R10
         r_next.slot_pend = 1'b0;
      end
      if (eval && run_on && trig && !r_reg.slot_pend) begin
         r_next.slot_pend = 1'b1; // see R7
         // one shot: drop the run action so the slot is not re-entered forever
         if (base == ppe_pkg::M_RUN) begin
            r_next.mode = {latched, ppe_pkg::M_OFF_KEEP}; // see R15
         end else begin
            r_next.mode = {latched, ppe_pkg::M_OUT_WAIT}; // see R15
         end
      end

      // a pending wait is released by a trigger, only in the wait-capable modes
      if (eval && wait_req && outs_on && trig) begin
         r_next.wait_pulse = 1'b1; // see R9, R7
      end

      if (wr) begin
         unique case (paddr)
            ppe_pkg::OFS_MODE: begin
               // clear modes leave the mode alone and the pins at their present level
               if (pwdata[2:0] == ppe_pkg::M_CLR_IN) begin
                  r_next.in_mask = ppe_pkg::MASK_RST; // see R13
                  r_next.in_level = ppe_pkg::MASK_RST;
               end else if (pwdata[2:0] == ppe_pkg::M_CLR_OUT || pwdata[2:0] == ppe_pkg::M_CLR_BOTH) begin
                  // outputs are handed over to gpio at their present level
                  r_next.gp_out = keep_out; // see R13
                  r_next.gp_dir = keep_dir;
                  r_next.out_mask = ppe_pkg::MASK_RST;
                  r_next.out_level = ppe_pkg::MASK_RST;
                  if (pwdata[2:0] == ppe_pkg::M_CLR_BOTH) begin
                     r_next.in_mask = ppe_pkg::MASK_RST;
                     r_next.in_level = ppe_pkg::MASK_RST;
                  end
               end else begin
                  r_next.mode = pwdata[3:0]; // see R8
                  r_next.slot_pend = 1'b0;
                  // a new mode drops a slot switch armed in this same cycle; one already pending still fires
                  if (pwdata[2:0] == ppe_pkg::M_OFF_CLEAR) begin
                     // full clear: configuration gone, pins keep their level as gpio
                     r_next.gp_out = keep_out;
                     r_next.gp_dir = keep_dir;
                     r_next.in_mask = ppe_pkg::MASK_RST; // see R13
                     r_next.in_level = ppe_pkg::MASK_RST;
                     r_next.out_mask = ppe_pkg::MASK_RST;
                     r_next.out_level = ppe_pkg::MASK_RST;
                     r_next.out_state = 1'b0;
                     r_next.hit = hit_set;
                  end
               end
            end
            ppe_pkg::OFS_IN_DEF: begin
               // adding a pin keeps every earlier definition
               r_next.in_mask[def_idx] = 1'b1; // see R3, R1
               r_next.in_level[def_idx] = pwdata[ppe_pkg::DEF_LEVEL_BIT];
               r_next.gp_dir[def_idx] = 1'b0; // see R17
            end
            // a reacting output takes over its pin at once, even while polling is off
            ppe_pkg::OFS_OUT_DEF: begin
               r_next.out_mask[def_idx] = 1'b1; // see R3
               r_next.out_level[def_idx] = pwdata[ppe_pkg::DEF_LEVEL_BIT];
            end
            ppe_pkg::OFS_SLOT: begin
               r_next.slot = pwdata[2:0];
            end
            ppe_pkg::OFS_CLEAR: begin
               // a match in this very cycle survives the clear in non-latched modes only; a latched output is cleared regardless
               if (pwdata[ppe_pkg::CLR_LATCH_BIT]) begin
                  r_next.out_state = outs_on && eval && trig && !latched; // see R6
               end
               if (pwdata[ppe_pkg::CLR_HIT_BIT]) begin
                  r_next.hit = hit_set;
               end
            end
            // software cannot turn a watched input into an output through gpio
            ppe_pkg::OFS_GPIO: begin
               r_next.gp_out = pwdata[15:0];
               r_next.gp_dir = pwdata[31:16] & ~r_reg.in_mask; // see R17
            end
            default: begin
               r_next.gp_out = r_reg.gp_out;
            end
         endcase
      end

      // pins follow the next output state, so they lead any slot switch
      // a pin defined both ways stays an input: a watched pin is never driven
      r_next.pin_oe = (r_next.out_mask | r_next.gp_dir) & ~r_next.in_mask; // see R18, R17
      r_next.pin_out = (r_next.out_mask & (r_next.out_level ^ {16{~r_next.out_state}}))
         | (~r_next.out_mask & r_next.gp_out); // see R4, R5

      // read data and error are captured in the setup cycle; access phase ends at once
      // capturing early costs a flop stage on the read path but keeps pready constant,
      // so the master never sees a wait state on any register
      // the scratch window is decoded by word index, registers by byte address
      if (setup) begin
         r_next.pslverr = 1'b0;
         r_next.prdata = 32'h0000_0000;
         if (word_idx >= ppe_pkg::SCR_FIRST && word_idx <= ppe_pkg::SCR_LAST) begin
            unique case (word_idx[2:0])
               3'h0: r_next.prdata = {24'h00_0000, r_reg.hit[7:0]}; // see R11
               3'h1: r_next.prdata = {24'h00_0000, r_reg.hit[15:8]};
               3'h2: r_next.prdata = {28'h000_0000, r_reg.mode};
               3'h3: r_next.prdata = {29'h0000_0000, r_reg.slot};
               3'h4: r_next.prdata = {30'h0000_0000, r_reg.slot_pend, r_reg.out_state};
               default: r_next.prdata = 32'h0000_0000;
            endcase
         end else begin
            unique case (paddr)
               ppe_pkg::OFS_MODE: r_next.prdata = {28'h000_0000, r_reg.mode};
               ppe_pkg::OFS_IN_DEF: r_next.prdata = {r_reg.in_level, r_reg.in_mask};
               ppe_pkg::OFS_OUT_DEF: r_next.prdata = {r_reg.out_level, r_reg.out_mask};
               ppe_pkg::OFS_SLOT: r_next.prdata = {29'h0000_0000, r_reg.slot};
               ppe_pkg::OFS_STATUS: r_next.prdata = {r_reg.hit, 8'h00, r_reg.slot_pend, active,
                  r_reg.out_state, latched, r_reg.mode};
               ppe_pkg::OFS_CLEAR: r_next.prdata = 32'h0000_0000;
               ppe_pkg::OFS_GPIO: r_next.prdata = {r_reg.gp_dir, r_reg.gp_out};
               ppe_pkg::OFS_PINS: r_next.prdata = {16'h0000, smp.pin_level};
               default: r_next.pslverr = 1'b1;
            endcase
         end
      end
   end

   // synchronous reset: everything cleared, polling off, pins released
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
         r_reg.mode <= ppe_pkg::MODE_RST; // see R18
         r_reg.slot <= ppe_pkg::SLOT_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // every data output comes straight from a flop; only the bus error is gated
   // so that it stands in the access phase alone
   assign prdata = r_reg.prdata;
   assign pready = 1'b1;
   assign pslverr = r_reg.pslverr && psel && penable;
   assign wait_release = r_reg.wait_pulse;
   assign slot_switch = r_reg.slot_pulse;
   assign slot_target = r_reg.slot;
   assign pin_out = r_reg.pin_out;
   assign pin_oe = r_reg.pin_oe;
endmodule
`default_nettype wire

// ---- rtl/ppe_pkg.sv ----
// package: register map, mode codes and reset values of the polled pin-event unit
package ppe_pkg;
   localparam int PIN_N = 16;
   localparam int SLOT_W = 3;
   localparam int AW = 12;

   // register byte offsets
   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_IN_DEF = 12'h004;
   localparam logic [11:0] OFS_OUT_DEF = 12'h008;
   localparam logic [11:0] OFS_SLOT = 12'h00c;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_CLEAR = 12'h014;
   localparam logic [11:0] OFS_GPIO = 12'h018;
   localparam logic [11:0] OFS_PINS = 12'h01c;

   // scratch status locations, byte address is four times the index
   localparam logic [9:0] SCR_FIRST = 10'h080;
   localparam logic [9:0] SCR_LAST = 10'h087;

   // field positions
   localparam int DEF_IDX_LSB = 0;
   localparam int DEF_LEVEL_BIT = 8;
   localparam int CLR_LATCH_BIT = 0;
   localparam int CLR_HIT_BIT = 1;
   localparam int MODE_LATCH_BIT = 3;

   // base mode codes (low three bits of the mode)
   localparam logic [2:0] M_OFF_CLEAR = 3'h0;
   localparam logic [2:0] M_OFF_KEEP = 3'h1;
   localparam logic [2:0] M_OUT_WAIT = 3'h2;
   localparam logic [2:0] M_RUN = 3'h3;
   localparam logic [2:0] M_OUT_RUN = 3'h4;
   localparam logic [2:0] M_CLR_IN = 3'h5;
   localparam logic [2:0] M_CLR_OUT = 3'h6;
   localparam logic [2:0] M_CLR_BOTH = 3'h7;

   // values after reset
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [SLOT_W-1:0] SLOT_RST = 3'h0;
endpackage

// ---- rtl/ppe_sample_if.sv ----
// interface: pin sampling path between the control core and the sampler
`timescale 1ns/1ns
`default_nettype none
interface ppe_sample_if;
   logic [15:0] watch_mask;
   logic [15:0] watch_level;
   logic [15:0] pin_level;
   logic [15:0] match;
   logic trigger;

   modport core (output watch_mask, output watch_level, input pin_level, input match, input trigger);
   modport sampler (input watch_mask, input watch_level, output pin_level, output match, output trigger);
endinterface
`default_nettype wire

// ---- rtl/ppe_sampler.sv ----
// pin synchroniser and poll-level match of the polled pin-event unit
`timescale 1ns/1ns
`default_nettype none
module ppe_sampler (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] pin_in,
   ppe_sample_if.sampler smp
);
   typedef struct packed {
      logic [15:0] meta;
      logic [15:0] sync;
   } ppe_sync_t;

   ppe_sync_t r_reg;
   ppe_sync_t r_next;

   // two flops per pin; only the second stage is looked at
   always_comb begin
      r_next = r_reg;
      r_next.meta = pin_in;
      r_next.sync = r_reg.meta;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // a pin matches when it sits at its poll level; any match triggers
   assign smp.pin_level = r_reg.sync;
   assign smp.match = ~(r_reg.sync ^ smp.watch_level) & smp.watch_mask; // see R17
   assign smp.trigger = |smp.match; // see R4
endmodule
`default_nettype wire
